// ---- rtl/link_partner_pkg.sv ----
// Shared constants and carrier types of the link partner register bank
package link_partner_pkg;

  // Register indices; the byte address on the bus is four times the index
  localparam logic [5:0] IDX_DATAPATH = 6'h33;
  localparam logic [5:0] IDX_RSVD_34  = 6'h34;
  localparam logic [5:0] IDX_CAPS     = 6'h35;
  localparam logic [5:0] IDX_RSVD_36  = 6'h36;
  localparam logic [5:0] IDX_PADDR    = 6'h37;
  localparam logic [5:0] IDX_RSVD_38  = 6'h38;
  localparam logic [5:0] IDX_REMAP_0  = 6'h39;
  localparam logic [5:0] IDX_REMAP_1  = 6'h3A;

  // Field positions
  localparam int unsigned DP_RSVD_LSB   = 3;
  localparam int unsigned CRC_EN_BIT    = 2;
  localparam int unsigned GPIO_LSB      = 0;
  localparam int unsigned HOLD_CAPS_BIT = 7;
  localparam int unsigned CAP_RSVD_BIT  = 6;
  localparam int unsigned SELFTEST_BIT  = 5;
  localparam int unsigned MULTIPORT_BIT = 4;
  localparam int unsigned PORT_LSB      = 0;
  localparam int unsigned ADDR_LSB      = 1;
  localparam int unsigned HOLD_ADDR_BIT = 0;

  // Reset values
  localparam logic [4:0] DP_RSVD_RST   = 5'h00;
  localparam logic       CRC_EN_RST    = 1'h1;
  localparam logic [1:0] GPIO_RST      = 2'h0;
  localparam logic [7:0] RSVD_RST      = 8'h00;
  localparam logic       HOLD_CAPS_RST = 1'h0;
  localparam logic [3:0] PORT_RST      = 4'h0;
  localparam logic       HOLD_ADDR_RST = 1'h0;
  localparam logic [6:0] REMAP_RST     = 7'h00;

  // Forward GPIO count codes
  localparam logic [1:0] GPIO_NONE = 2'h0;
  localparam logic [1:0] GPIO_ONE  = 2'h1;
  localparam logic [1:0] GPIO_TWO  = 2'h2;
  localparam logic [1:0] GPIO_FOUR = 2'h3;

  // Control sequence: CRC covers this many bytes and follows them
  localparam logic [3:0] SEQ_BYTES = 4'h8;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } seq_byte_t;

  typedef struct packed {
    logic       valid;
    logic       selftest;
    logic       multiport;
    logic [3:0] port_num;
  } cap_update_t;

  typedef struct packed {
    logic       valid;
    logic [6:0] addr;
  } addr_update_t;

  typedef struct packed {
    logic       valid;
    logic [6:0] addr;
    logic       rw;
  } i2c_addr_t;

endpackage

// ---- rtl/control_seq_crc.sv ----
// Running CRC-8 over the bytes of one forward control sequence
`timescale 1ns/1ps
module control_seq_crc #(
  parameter logic [7:0] POLY = 8'h07
) (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       byte_valid,
  input  wire logic       first_byte,
  input  wire logic [7:0] byte_data,
  output logic      [7:0] crc
);

  logic [7:0] next_crc;

  always_comb begin
    logic [7:0] x;
    x = (first_byte ? 8'h00 : crc) ^ byte_data;
    for (int i = 0; i < 8; i++) begin
      x = x[7] ? ((x << 1) ^ POLY) : (x << 1);
    end
    next_crc = x;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      crc <= 8'h00;
    end else if (byte_valid) begin
      crc <= next_crc;
    end
  end

endmodule

// ---- rtl/link_partner_config_regs.sv ----
// Link partner configuration and status registers with APB access
//
// Behaviour
// - CRC enable set: append CRC to sequences
// - CRC over first eight bytes, sent ninth
// - GPIO code selects zero, one, two, four
// - Capability hold stops back channel capability updates
// - Link up, unheld: load partner capabilities
// - Self-test bit shows partner self-test request
// - Multi-port flag: zero single, one multi
// - Four-bit partner port number field
// - Partner address loads from back channel
// - Address hold keeps software written address
// - Alias 0/1 hits remapped to entry
`timescale 1ns/1ps
module link_partner_config_regs #(
  // Arbitrary value
  parameter logic [6:0] PARTNER_ADDR_RST = 7'h10,
  parameter logic [7:0] CRC_POLY         = 8'h07
) (
  input  wire logic                          clk,
  input  wire logic                          reset,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [7:0]                    paddr,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire logic                          bc_link_detected,
  input  wire link_partner_pkg::cap_update_t  cap_update,
  input  wire link_partner_pkg::addr_update_t addr_update,
  input  wire link_partner_pkg::seq_byte_t    seq_in,
  output logic                               seq_ready,
  output link_partner_pkg::seq_byte_t         fwd_out,
  output logic      [2:0]                    fwd_gpio_count,
  input  wire logic [6:0]                    alias_0,
  input  wire logic [6:0]                    alias_1,
  input  wire link_partner_pkg::i2c_addr_t    i2c_in,
  output link_partner_pkg::i2c_addr_t         i2c_out,
  output logic                               i2c_alias_hit
);

  generate
    if (CRC_POLY[0] != 1'b1) begin : g_bad_poly
      $error("CRC polynomial must have its lowest bit set");
    end
  endgenerate

  typedef struct packed {
    logic [4:0]                  dp_rsvd;
    logic                        crc_en;
    logic [1:0]                  gpio_code;
    logic [7:0]                  rsvd_34;
    logic                        hold_caps;
    logic                        cap_rsvd;
    logic                        selftest;
    logic                        multiport;
    logic [3:0]                  port_num;
    logic [7:0]                  rsvd_36;
    logic [6:0]                  partner_addr;
    logic                        hold_addr;
    logic [7:0]                  rsvd_38;
    logic [6:0]                  remap_0;
    logic [6:0]                  remap_1;
    logic                        ack;
    logic                        slverr;
    logic [31:0]                 rdata;
    logic [3:0]                  seq_cnt;
    logic                        crc_slot;
    link_partner_pkg::seq_byte_t fwd;
    link_partner_pkg::i2c_addr_t i2c;
    logic                        hit;
  } state_t;

  state_t     st;
  state_t     next_st;
  logic [5:0] idx;
  logic       mapped;
  logic       commit_wr;
  logic       seq_take;
  logic       seq_last;
  logic [7:0] crc_value;
  logic [7:0] rd_value;

  assign idx = paddr[7:2];

  always_comb begin
    mapped = (paddr[1:0] == 2'h0) &&
             (idx >= link_partner_pkg::IDX_DATAPATH) &&
             (idx <= link_partner_pkg::IDX_REMAP_1);
  end

  // Write takes effect at the edge where pready is sampled high
  assign commit_wr = psel && penable && st.ack && pwrite && mapped;

  assign seq_ready = !st.crc_slot;
  assign seq_take  = seq_in.valid && seq_ready;
  assign seq_last  = (st.seq_cnt == link_partner_pkg::SEQ_BYTES - 4'h1);

  control_seq_crc #(
    .POLY (CRC_POLY)
  ) u_crc (
    .clk        (clk),
    .reset      (reset),
    .byte_valid (seq_take),
    .first_byte (st.seq_cnt == 4'h0),
    .byte_data  (seq_in.data),
    .crc        (crc_value)
  );

  // Read mux
  always_comb begin
    rd_value = 8'h00;
    case (idx)
      link_partner_pkg::IDX_DATAPATH: begin
        rd_value = {st.dp_rsvd, st.crc_en, st.gpio_code};
      end
      link_partner_pkg::IDX_RSVD_34: begin
        rd_value = st.rsvd_34;
      end
      link_partner_pkg::IDX_CAPS: begin
        rd_value = {st.hold_caps, st.cap_rsvd, st.selftest,
                    st.multiport, st.port_num};
      end
      link_partner_pkg::IDX_RSVD_36: begin
        rd_value = st.rsvd_36;
      end
      link_partner_pkg::IDX_PADDR: begin
        rd_value = {st.partner_addr, st.hold_addr};
      end
      link_partner_pkg::IDX_RSVD_38: begin
        rd_value = st.rsvd_38;
      end
      link_partner_pkg::IDX_REMAP_0: begin
        rd_value = {st.remap_0, 1'b0};
      end
      link_partner_pkg::IDX_REMAP_1: begin
        rd_value = {st.remap_1, 1'b0};
      end
      default: begin
        rd_value = 8'h00;
      end
    endcase
    if (paddr[1:0] != 2'h0) begin
      rd_value = 8'h00;
    end
  end

  always_comb begin
    next_st           = st;
    next_st.ack       = 1'b0;
    next_st.fwd.valid = 1'b0;
    next_st.i2c.valid = 1'b0;
    next_st.hit       = 1'b0;

    // One wait state: answer prepared in the first access cycle
    if (psel && penable && !st.ack) begin
      next_st.ack    = 1'b1;
      next_st.slverr = !mapped;
      next_st.rdata  = pwrite ? 32'h0000_0000 : {24'h00_0000, rd_value};
    end

    // Back channel loads
    if (bc_link_detected && !st.hold_caps && cap_update.valid) begin
      next_st.selftest  = cap_update.selftest;
      next_st.multiport = cap_update.multiport;
      next_st.port_num  = cap_update.port_num;
    end
    if (bc_link_detected && !st.hold_addr && addr_update.valid) begin
      next_st.partner_addr = addr_update.addr;
    end

    // Software writes come last so they win over a coincident load
    if (commit_wr) begin
      case (idx)
        link_partner_pkg::IDX_DATAPATH: begin
          next_st.dp_rsvd   = pwdata[link_partner_pkg::DP_RSVD_LSB +: 5];
          next_st.crc_en    = pwdata[link_partner_pkg::CRC_EN_BIT];
          next_st.gpio_code = pwdata[link_partner_pkg::GPIO_LSB +: 2];
        end
        link_partner_pkg::IDX_RSVD_34: begin
          next_st.rsvd_34 = pwdata[7:0];
        end
        link_partner_pkg::IDX_CAPS: begin
          next_st.hold_caps = pwdata[link_partner_pkg::HOLD_CAPS_BIT];
          next_st.cap_rsvd  = pwdata[link_partner_pkg::CAP_RSVD_BIT];
          next_st.selftest  = pwdata[link_partner_pkg::SELFTEST_BIT];
          next_st.multiport = pwdata[link_partner_pkg::MULTIPORT_BIT];
          next_st.port_num  = pwdata[link_partner_pkg::PORT_LSB +: 4];
        end
        link_partner_pkg::IDX_RSVD_36: begin
          next_st.rsvd_36 = pwdata[7:0];
        end
        link_partner_pkg::IDX_PADDR: begin
          next_st.partner_addr = pwdata[link_partner_pkg::ADDR_LSB +: 7];
          next_st.hold_addr    = pwdata[link_partner_pkg::HOLD_ADDR_BIT];
        end
        link_partner_pkg::IDX_RSVD_38: begin
          next_st.rsvd_38 = pwdata[7:0];
        end
        link_partner_pkg::IDX_REMAP_0: begin
          next_st.remap_0 = pwdata[link_partner_pkg::ADDR_LSB +: 7];
        end
        link_partner_pkg::IDX_REMAP_1: begin
          next_st.remap_1 = pwdata[link_partner_pkg::ADDR_LSB +: 7];
        end
        default: begin
          next_st.rsvd_38 = st.rsvd_38;
        end
      endcase
    end

    // Forward control sequence; CRC slot stalls the source one cycle
    if (st.crc_slot) begin
      next_st.fwd.valid = 1'b1;
      next_st.fwd.data  = crc_value;
      next_st.crc_slot  = 1'b0;
    end else if (seq_in.valid) begin
      next_st.fwd = seq_in;
      if (seq_last) begin
        next_st.seq_cnt  = 4'h0;
        next_st.crc_slot = st.crc_en;
      end else begin
        next_st.seq_cnt = st.seq_cnt + 4'h1;
      end
    end

    // Target address remap on alias match
    if (i2c_in.valid) begin
      next_st.i2c = i2c_in;
      if (i2c_in.addr == alias_0) begin
        next_st.i2c.addr = st.remap_0;
        next_st.hit      = 1'b1;
      end else if (i2c_in.addr == alias_1) begin
        next_st.i2c.addr = st.remap_1;
        next_st.hit      = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st              <= '0;
      st.dp_rsvd      <= link_partner_pkg::DP_RSVD_RST;
      st.crc_en       <= link_partner_pkg::CRC_EN_RST;
      st.gpio_code    <= link_partner_pkg::GPIO_RST;
      st.rsvd_34      <= link_partner_pkg::RSVD_RST;
      st.hold_caps    <= link_partner_pkg::HOLD_CAPS_RST;
      st.port_num     <= link_partner_pkg::PORT_RST;
      st.rsvd_36      <= link_partner_pkg::RSVD_RST;
      st.partner_addr <= PARTNER_ADDR_RST;
      st.hold_addr    <= link_partner_pkg::HOLD_ADDR_RST;
      st.rsvd_38      <= link_partner_pkg::RSVD_RST;
      st.remap_0      <= link_partner_pkg::REMAP_RST;
      st.remap_1      <= link_partner_pkg::REMAP_RST;
    end else begin
      st <= next_st;
    end
  end

  assign prdata        = st.rdata;
  assign pready        = st.ack;
  assign pslverr       = st.ack && st.slverr;
  assign fwd_out       = st.fwd;
  assign i2c_out       = st.i2c;
  assign i2c_alias_hit = st.hit;

  // Forward GPIO count decode
  always_comb begin
    case (st.gpio_code)
      link_partner_pkg::GPIO_NONE: fwd_gpio_count = 3'h0;
      link_partner_pkg::GPIO_ONE:  fwd_gpio_count = 3'h1;
      link_partner_pkg::GPIO_TWO:  fwd_gpio_count = 3'h2;
      link_partner_pkg::GPIO_FOUR: fwd_gpio_count = 3'h4;
      default:                     fwd_gpio_count = 3'h0;
    endcase
  end

  chk_crc_slot_armed: assert property (
    @(posedge clk) disable iff (reset)
    (seq_take && seq_last && st.crc_en) |=> (st.crc_slot && !seq_ready))
    else $error("CRC slot not opened after eighth byte");

  chk_crc_slot_absent: assert property (
    @(posedge clk) disable iff (reset)
    (seq_take && seq_last && !st.crc_en) |=> !st.crc_slot)
    else $error("CRC slot opened while CRC disabled");

  chk_crc_ninth_byte: assert property (
    @(posedge clk) disable iff (reset)
    (seq_take && seq_last && st.crc_en)
      |=> ##1 (fwd_out.valid && fwd_out.data == $past(crc_value)))
    else $error("Ninth byte is not the CRC");

  chk_gpio_count_map: assert property (
    @(posedge clk) disable iff (reset)
    fwd_gpio_count == ((st.gpio_code == 2'h3) ? 3'h4 : {1'b0, st.gpio_code}))
    else $error("GPIO count does not match code");

  chk_caps_held: assert property (
    @(posedge clk) disable iff (reset)
    (st.hold_caps && !(commit_wr && idx == link_partner_pkg::IDX_CAPS))
      |=> $stable({st.selftest, st.multiport, st.port_num}))
    else $error("Held capabilities changed");

  chk_caps_loaded: assert property (
    @(posedge clk) disable iff (reset)
    (bc_link_detected && !st.hold_caps && cap_update.valid &&
     !(commit_wr && idx == link_partner_pkg::IDX_CAPS))
      |=> ({st.selftest, st.multiport, st.port_num} ==
           $past({cap_update.selftest, cap_update.multiport, cap_update.port_num})))
    else $error("Capabilities not loaded from back channel");

  chk_addr_loaded: assert property (
    @(posedge clk) disable iff (reset)
    (bc_link_detected && !st.hold_addr && addr_update.valid &&
     !(commit_wr && idx == link_partner_pkg::IDX_PADDR))
      |=> st.partner_addr == $past(addr_update.addr))
    else $error("Partner address not loaded");

  chk_addr_held: assert property (
    @(posedge clk) disable iff (reset)
    (st.hold_addr && !(commit_wr && idx == link_partner_pkg::IDX_PADDR))
      |=> $stable(st.partner_addr))
    else $error("Held partner address changed");

  chk_alias_remap: assert property (
    @(posedge clk) disable iff (reset)
    (i2c_in.valid && i2c_in.addr == alias_0)
      |=> (i2c_out.valid && i2c_alias_hit && i2c_out.addr == $past(st.remap_0) &&
           i2c_out.rw == $past(i2c_in.rw)))
    else $error("Alias 0 not remapped");

  chk_apb_one_wait: assert property (
    @(posedge clk) disable iff (reset)
    (psel && penable && !pready) |=> pready)
    else $error("APB answer late");

endmodule

// ---- bench/deser_partner_model.sv ----
// Behavioural model of the remote deserializer feeding the back channel
`timescale 1ns/1ps
module deser_partner_model (
  input  wire logic                          clk,
  output logic                               bc_link_detected,
  output link_partner_pkg::cap_update_t      cap_update,
  output link_partner_pkg::addr_update_t     addr_update
);
  initial begin
    bc_link_detected = 1'b0;
    cap_update = '0;
    addr_update = '0;
  end

  task automatic set_link(input logic up);
    @(posedge clk);
    bc_link_detected <= up;
  endtask

  // One-cycle capability report: self-test, multi-port, port number
  task automatic send_caps(input logic st, input logic mp, input logic [3:0] port);
    @(posedge clk);
    cap_update <= {1'b1, st, mp, port};
    @(posedge clk);
    cap_update <= '0;
  endtask

  task automatic send_addr(input logic [6:0] addr);
    @(posedge clk);
    addr_update <= {1'b1, addr};
    @(posedge clk);
    addr_update <= '0;
  endtask
endmodule

// ---- bench/link_partner_config_regs_bench.sv ----
// Self-checking bench for the link partner register bank
`timescale 1ns/1ps
module link_partner_config_regs_bench;
  logic                           clk;
  logic                           reset;
  logic                           psel;
  logic                           penable;
  logic                           pwrite;
  logic [7:0]                     paddr;
  logic [31:0]                    pwdata;
  logic [31:0]                    prdata;
  logic                           pready;
  logic                           pslverr;
  logic                           bc_link_detected;
  link_partner_pkg::cap_update_t  cap_update;
  link_partner_pkg::addr_update_t addr_update;
  link_partner_pkg::seq_byte_t    seq_in;
  logic                           seq_ready;
  link_partner_pkg::seq_byte_t    fwd_out;
  logic [2:0]                     fwd_gpio_count;
  logic [6:0]                     alias_0;
  logic [6:0]                     alias_1;
  link_partner_pkg::i2c_addr_t    i2c_in;
  link_partner_pkg::i2c_addr_t    i2c_out;
  logic                           i2c_alias_hit;
  int                             failures;
  int                             checked;
  logic [31:0]                    mis_rd;
  logic                           mis_err;
  logic [7:0]                     got[$];
  logic [7:0]                     rst_val[8] = '{8'h04, 8'h00, 8'h00, 8'h00, 8'h20, 8'h00, 8'h00, 8'h00};

  link_partner_config_regs #(.PARTNER_ADDR_RST(7'h10), .CRC_POLY(8'h07)) link_partner_config_regs_inst (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bc_link_detected(bc_link_detected), .cap_update(cap_update), .addr_update(addr_update),
    .seq_in(seq_in), .seq_ready(seq_ready), .fwd_out(fwd_out), .fwd_gpio_count(fwd_gpio_count),
    .alias_0(alias_0), .alias_1(alias_1), .i2c_in(i2c_in), .i2c_out(i2c_out), .i2c_alias_hit(i2c_alias_hit)
  );

  deser_partner_model deser_partner_model_inst (
    .clk(clk), .bc_link_detected(bc_link_detected), .cap_update(cap_update), .addr_update(addr_update)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (fwd_out.valid === 1'b1) begin
      got.push_back(fwd_out.data);
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // Wait for the answer; only the watchdog ends a hung transfer
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr_reg(input logic [5:0] idx, input logic [7:0] v);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, {idx, 2'b00}, {24'h0, v}, rd, err);
  endtask

  task automatic rd_chk(input logic [5:0] idx, input logic [7:0] exp, input logic exp_err);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, {idx, 2'b00}, 32'h0, rd, err);
    check(rd, {24'h0, exp});
    check({31'h0, err}, {31'h0, exp_err});
  endtask

  // Reference CRC-8, MSB first, zero start
  function automatic logic [7:0] crc_ref(input logic [7:0] base);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < 8; i++) begin
      c = c ^ (base + 8'(i));
      for (int j = 0; j < 8; j++) begin
        c = c[7] ? ((c << 1) ^ 8'h07) : (c << 1);
      end
    end
    return c;
  endfunction

  task automatic send_group(input logic [7:0] base);
    for (int i = 0; i < 8; i++) begin
      seq_in <= {1'b1, base + 8'(i)};
      do begin
        @(posedge clk);
      end while (seq_ready !== 1'b1);
    end
    seq_in <= '0;
    repeat (4) @(posedge clk);
  endtask

  task automatic i2c(input logic [6:0] a, input logic rw, input logic [6:0] ea, input logic hit);
    i2c_in <= {1'b1, a, rw};
    @(posedge clk);
    i2c_in <= '0;
    @(posedge clk);
    check(32'(i2c_out), 32'({1'b1, ea, rw}));
    check({31'h0, i2c_alias_hit}, {31'h0, hit});
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    tally_and_finish;
  end

  initial begin
    failures = 0;
    checked = 0;
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    seq_in = '0;
    alias_0 = 7'h50;
    alias_1 = 7'h51;
    i2c_in = '0;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      rd_chk(6'h33 + 6'(i), rst_val[i], 1'b0);
    end
    check(32'(fwd_gpio_count), 32'h0);
    rd_chk(6'h32, 8'h00, 1'b1);
    wr_reg(6'h3B, 8'h5A);
    rd_chk(6'h3B, 8'h00, 1'b1);
    // Misaligned byte address: refused, write ignored, read zero
    apb(1'b1, 8'hCD, 32'h0000_00FF, mis_rd, mis_err);
    check({31'h0, mis_err}, 32'h1);
    apb(1'b0, 8'hCD, 32'h0, mis_rd, mis_err);
    check(mis_rd, 32'h0);
    check({31'h0, mis_err}, 32'h1);
    rd_chk(6'h33, 8'h04, 1'b0);
    $display("test reset and map done");
    for (int c = 0; c < 4; c++) begin
      wr_reg(6'h33, 8'h04 | 8'(c));
      @(posedge clk);
      check(32'(fwd_gpio_count), (c == 3) ? 32'h4 : 32'(c));
    end
    for (int i = 0; i < 3; i++) begin
      wr_reg(6'h34 + 6'(2 * i), 8'hA5);
      rd_chk(6'h34 + 6'(2 * i), 8'hA5, 1'b0);
    end
    wr_reg(6'h39, 8'hFF);
    rd_chk(6'h39, 8'hFE, 1'b0);
    $display("test register access done");
    deser_partner_model_inst.set_link(1'b1);
    deser_partner_model_inst.send_caps(1'b1, 1'b1, 4'hA);
    rd_chk(6'h35, 8'h3A, 1'b0);
    deser_partner_model_inst.send_caps(1'b0, 1'b0, 4'h3);
    rd_chk(6'h35, 8'h03, 1'b0);
    wr_reg(6'h35, 8'hA5);
    deser_partner_model_inst.send_caps(1'b0, 1'b1, 4'hC);
    rd_chk(6'h35, 8'hA5, 1'b0);
    deser_partner_model_inst.send_addr(7'h55);
    rd_chk(6'h37, 8'hAA, 1'b0);
    wr_reg(6'h37, 8'h33);
    deser_partner_model_inst.send_addr(7'h6E);
    rd_chk(6'h37, 8'h33, 1'b0);
    wr_reg(6'h35, 8'h00);
    deser_partner_model_inst.set_link(1'b0);
    deser_partner_model_inst.send_caps(1'b1, 1'b1, 4'h7);
    rd_chk(6'h35, 8'h00, 1'b0);
    $display("test back channel done");
    wr_reg(6'h39, 8'h44);
    wr_reg(6'h3A, 8'h88);
    i2c(7'h50, 1'b1, 7'h22, 1'b1);
    i2c(7'h51, 1'b0, 7'h44, 1'b1);
    i2c(7'h52, 1'b1, 7'h52, 1'b0);
    // Aliases move at run time; equal aliases give entry 0 priority
    alias_0 <= 7'h52;
    alias_1 <= 7'h52;
    i2c(7'h52, 1'b0, 7'h22, 1'b1);
    alias_0 <= 7'h60;
    alias_1 <= 7'h61;
    i2c(7'h61, 1'b1, 7'h44, 1'b1);
    i2c(7'h50, 1'b0, 7'h50, 1'b0);
    $display("test remap done");
    wr_reg(6'h33, 8'h04);
    send_group(8'hA0);
    check(32'(got.size()), 32'd9);
    check(32'(got[7]), 32'hA7);
    check(32'(got[8]), 32'(crc_ref(8'hA0)));
    wr_reg(6'h33, 8'h00);
    send_group(8'h10);
    check(32'(got.size()), 32'd17);
    $display("test control sequence done");
    tally_and_finish;
  end
endmodule
